// [pbs_regs.svh]
// Timing and reset constants for the push button power sequencer
`ifndef PBS_REGS_SVH
`define PBS_REGS_SVH
`define PBS_CLK_HZ        40000000
`define PBS_TICK_MS       1
`define PBS_DEBOUNCE_MS   32
`define PBS_BLANK_MS      512
`define PBS_OFF_DELAY_MS  1024
`define PBS_LOCKOUT_MS    256
`define PBS_TICK_CYCLES   ((`PBS_CLK_HZ / 1000) * `PBS_TICK_MS)
`define PBS_ALERT_RESET   1'b1
`define PBS_RELEASED_RESET 1'b1
`endif

// [pbs_pkg.sv]
// Types shared by the push button power sequencer
`default_nettype none
package pbs_pkg;
	typedef enum logic [6:0] {
		PBS_OFF_WAIT = 7'h01,
		PBS_ON_QUAL  = 7'h02,
		PBS_BLANK    = 7'h04,
		PBS_REL_DB   = 7'h08,
		PBS_RUN      = 7'h10,
		PBS_GRACE    = 7'h20,
		PBS_LOCKOUT  = 7'h40
	} pbs_state_type;
endpackage : pbs_pkg
`default_nettype wire

// [pbs_tick.sv]
// Millisecond tick prescaler for the power sequencer timers
`timescale 1ns/1ps
`default_nettype none
`include "pbs_regs.svh"
module pbs_tick #(
	parameter int DIVIDE = `PBS_TICK_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic reset_i,
	output var  logic tick_o
);
	logic [31:0] count;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			count  <= 32'h0;
			tick_o <= 1'b0;
		end else if (count >= 32'(DIVIDE - 1)) begin
			count  <= 32'h0;
			tick_o <= 1'b1;
		end else begin
			count  <= count + 32'h1;
			tick_o <= 1'b0;
		end
	end
endmodule : pbs_tick
`default_nettype wire

// [pbs_sequencer.sv]
// Push button power on/off sequencer with host shutdown handshake
`timescale 1ns/1ps
`default_nettype none
`include "pbs_regs.svh"
module pbs_sequencer #(
	parameter bit SUPPLY_ACTIVE_HIGH = 1'b1,
	parameter int TICK_CYCLES        = `PBS_TICK_CYCLES,
	parameter int EXT_WIDTH          = 16
) (
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	input  wire logic                 push_button_n_i,
	input  wire logic                 power_hold_n_i,
	input  wire logic [EXT_WIDTH-1:0] on_extend_i,
	input  wire logic [EXT_WIDTH-1:0] off_extend_i,
	output var  logic                 supply_on_out_o,
	output var  logic                 supply_on_oe_o,
	output var  logic                 shutdown_alert_n_o,
	output var  logic                 shutdown_alert_oe_o,
	output var  logic                 power_on_o
);
	localparam logic [15:0] DEBOUNCE_MS = 16'(`PBS_DEBOUNCE_MS);
	localparam logic [15:0] BLANK_MS    = 16'(`PBS_BLANK_MS);
	localparam logic [15:0] DELAY_MS    = 16'(`PBS_OFF_DELAY_MS);
	localparam logic [15:0] LOCKOUT_MS  = 16'(`PBS_LOCKOUT_MS);

	pbs_pkg::pbs_state_type state;
	logic                   tick;
	logic [16:0]            ms_count;
	logic [16:0]            on_target;
	logic [16:0]            off_target;
	logic                   timer_done_on;
	logic                   timer_done_off;
	logic                   rel_ok;
	logic [16:0]            rel_count;

	// Prescaled millisecond tick for every timer
	pbs_tick #(
		.DIVIDE (TICK_CYCLES)
	) u_tick (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.tick_o  (tick)
	);

	assign on_target      = 17'(DEBOUNCE_MS) + 17'(on_extend_i);
	assign off_target     = 17'(DEBOUNCE_MS) + 17'(off_extend_i);
	assign timer_done_on  = tick && (ms_count + 17'h1 >= on_target);
	assign timer_done_off = tick && (ms_count + 17'h1 >= off_target);

	function automatic logic reached(input logic [16:0] cnt, input logic [15:0] lim);
		reached = (cnt + 17'h1 >= 17'(lim));
	endfunction : reached

	// Phase sequencing; the counter restarts at every phase change
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state    <= pbs_pkg::PBS_OFF_WAIT;
			ms_count <= 17'h0;
		end else begin
			case (state)
				pbs_pkg::PBS_OFF_WAIT: begin
					ms_count <= 17'h0;
					if (!push_button_n_i && rel_ok) begin
						state <= pbs_pkg::PBS_ON_QUAL;
					end
				end
				pbs_pkg::PBS_ON_QUAL: begin
					if (push_button_n_i) begin
						state    <= pbs_pkg::PBS_OFF_WAIT;
						ms_count <= 17'h0;
					end else if (timer_done_on) begin
						state    <= pbs_pkg::PBS_BLANK;
						ms_count <= 17'h0;
					end else if (tick) begin
						ms_count <= ms_count + 17'h1;
					end
				end
				pbs_pkg::PBS_BLANK: begin
					// Both inputs ignored until the window closes
					if (tick && reached(ms_count, BLANK_MS)) begin
						ms_count <= 17'h0;
						if (!power_hold_n_i) begin
							state <= pbs_pkg::PBS_LOCKOUT;
						end else begin
							state <= pbs_pkg::PBS_REL_DB;
						end
					end else if (tick) begin
						ms_count <= ms_count + 17'h1;
					end
				end
				pbs_pkg::PBS_REL_DB: begin
					// Button must read released for the full debounce
					if (!power_hold_n_i) begin
						state    <= pbs_pkg::PBS_LOCKOUT;
						ms_count <= 17'h0;
					end else if (!push_button_n_i) begin
						ms_count <= 17'h0;
					end else if (tick && reached(ms_count, DEBOUNCE_MS)) begin
						state    <= pbs_pkg::PBS_RUN;
						ms_count <= 17'h0;
					end else if (tick) begin
						ms_count <= ms_count + 17'h1;
					end
				end
				pbs_pkg::PBS_RUN: begin
					if (!power_hold_n_i) begin
						state    <= pbs_pkg::PBS_LOCKOUT;
						ms_count <= 17'h0;
					end else if (push_button_n_i) begin
						ms_count <= 17'h0;
					end else if (timer_done_off) begin
						state    <= pbs_pkg::PBS_GRACE;
						ms_count <= 17'h0;
					end else if (tick) begin
						ms_count <= ms_count + 17'h1;
					end
				end
				pbs_pkg::PBS_GRACE: begin
					if (!power_hold_n_i) begin
						state    <= pbs_pkg::PBS_LOCKOUT;
						ms_count <= 17'h0;
					end else if (tick && reached(ms_count, DELAY_MS)) begin
						state    <= pbs_pkg::PBS_LOCKOUT;
						ms_count <= 17'h0;
					end else if (tick) begin
						ms_count <= ms_count + 17'h1;
					end
				end
				pbs_pkg::PBS_LOCKOUT: begin
					// Lets the converter output decay before a restart
					if (tick && reached(ms_count, LOCKOUT_MS)) begin
						ms_count <= 17'h0;
						state    <= pbs_pkg::PBS_OFF_WAIT;
					end else if (tick) begin
						ms_count <= ms_count + 17'h1;
					end
				end
				default: begin
					state    <= pbs_pkg::PBS_OFF_WAIT;
					ms_count <= 17'h0;
				end
			endcase
		end
	end

	// A button still held from the off press must not restart the supply
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rel_ok    <= `PBS_RELEASED_RESET;
			rel_count <= 17'h0;
		end else if (state == pbs_pkg::PBS_LOCKOUT) begin
			rel_ok    <= 1'b0;
			rel_count <= 17'h0;
		end else if (state == pbs_pkg::PBS_OFF_WAIT && !rel_ok) begin
			if (!push_button_n_i) begin
				rel_count <= 17'h0;
			end else if (tick && reached(rel_count, DEBOUNCE_MS)) begin
				rel_ok    <= 1'b1;
				rel_count <= 17'h0;
			end else if (tick) begin
				rel_count <= rel_count + 17'h1;
			end
		end
	end

	logic next_on;
	logic next_alert_low;
	always_comb begin
		next_on = 1'b0;
		next_alert_low = 1'b0;
		case (state)
			pbs_pkg::PBS_BLANK: next_on = 1'b1;
			pbs_pkg::PBS_REL_DB: next_on = 1'b1;
			pbs_pkg::PBS_RUN: next_on = 1'b1;
			pbs_pkg::PBS_GRACE: begin
				next_on        = 1'b1;
				next_alert_low = 1'b1;
			end
			default: begin
				next_on        = 1'b0;
				next_alert_low = 1'b0;
			end
		endcase
	end

	// Outputs registered; they trail the state by one clock
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			power_on_o          <= 1'b0;
			supply_on_out_o     <= ~SUPPLY_ACTIVE_HIGH;
			supply_on_oe_o      <= SUPPLY_ACTIVE_HIGH;
			shutdown_alert_n_o  <= `PBS_ALERT_RESET;
			shutdown_alert_oe_o <= 1'b0;
		end else begin
			power_on_o          <= next_on;
			supply_on_out_o     <= next_on ~^ SUPPLY_ACTIVE_HIGH;
			// Open drain: driven only while the level is low
			supply_on_oe_o      <= ~(next_on ~^ SUPPLY_ACTIVE_HIGH);
			shutdown_alert_n_o  <= ~next_alert_low;
			shutdown_alert_oe_o <= next_alert_low;
		end
	end

	on_level_a: assert property (@(posedge clk_i) disable iff (reset_i)
		power_on_o |-> supply_on_out_o == SUPPLY_ACTIVE_HIGH)
		else $error("supply level wrong for polarity");
	off_level_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!power_on_o |-> supply_on_out_o != SUPPLY_ACTIVE_HIGH
			&& supply_on_oe_o == SUPPLY_ACTIVE_HIGH)
		else $error("supply not released while off");
	blank_ignore_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == pbs_pkg::PBS_BLANK && !(tick && reached(ms_count, BLANK_MS)))
		|=> state == pbs_pkg::PBS_BLANK)
		else $error("blanking left early");
	abort_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == pbs_pkg::PBS_BLANK && tick && reached(ms_count, BLANK_MS) && !power_hold_n_i)
		|=> ##1 !power_on_o)
		else $error("power-up not aborted");
	on_qual_a: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(power_on_o) |-> $past(state, 2) == pbs_pkg::PBS_ON_QUAL)
		else $error("supply on without qualified press");
	on_window_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == pbs_pkg::PBS_ON_QUAL && !push_button_n_i && !timer_done_on)
		|=> state == pbs_pkg::PBS_ON_QUAL)
		else $error("turn-on qualified early");
	restart_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == pbs_pkg::PBS_ON_QUAL && push_button_n_i) |=> state == pbs_pkg::PBS_OFF_WAIT)
		else $error("debounce not restarted");
	off_window_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == pbs_pkg::PBS_RUN && power_hold_n_i && !push_button_n_i && !timer_done_off)
		|=> state == pbs_pkg::PBS_RUN)
		else $error("turn-off qualified early");
	run_restart_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == pbs_pkg::PBS_RUN && power_hold_n_i && push_button_n_i) |=> ms_count == 17'h0)
		else $error("off debounce not restarted");
	alert_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
		$fell(shutdown_alert_n_o) |-> power_on_o && $past(state) == pbs_pkg::PBS_GRACE)
		else $error("alert without turn-off");
	alert_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
		state == pbs_pkg::PBS_GRACE |=> !shutdown_alert_n_o && shutdown_alert_oe_o)
		else $error("alert not held through delay");
	grace_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == pbs_pkg::PBS_GRACE && power_hold_n_i
			&& !(tick && reached(ms_count, DELAY_MS))) |=> state == pbs_pkg::PBS_GRACE)
		else $error("turn-off delay cut short");
	hold_kill_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(!power_hold_n_i && (state == pbs_pkg::PBS_GRACE || state == pbs_pkg::PBS_RUN))
		|=> ##1 !power_on_o)
		else $error("hold low did not release supply");
	rel_kill_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == pbs_pkg::PBS_REL_DB && !power_hold_n_i) |=> ##1 !power_on_o)
		else $error("hold low ignored after blanking");
	alert_release_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!power_on_o |-> shutdown_alert_n_o)
		else $error("alert low with supply off");
	alert_idle_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!power_on_o |-> !shutdown_alert_oe_o)
		else $error("alert driven with supply off");
	lockout_a: assert property (@(posedge clk_i) disable iff (reset_i)
		$fell(power_on_o) |-> state == pbs_pkg::PBS_LOCKOUT)
		else $error("no lockout after release");
	lock_ignore_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == pbs_pkg::PBS_LOCKOUT && !(tick && reached(ms_count, LOCKOUT_MS)))
		|=> state == pbs_pkg::PBS_LOCKOUT)
		else $error("lockout left early");
	rel_wait_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == pbs_pkg::PBS_OFF_WAIT && !rel_ok) |=> state == pbs_pkg::PBS_OFF_WAIT)
		else $error("press taken before release debounce");
	delay_end_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == pbs_pkg::PBS_GRACE && tick && reached(ms_count, DELAY_MS))
		|=> state == pbs_pkg::PBS_LOCKOUT)
		else $error("delay expiry missed");

	power_up_c: cover property (@(posedge clk_i) disable iff (reset_i) $rose(power_on_o));
	shutdown_c: cover property (@(posedge clk_i) disable iff (reset_i) $fell(shutdown_alert_n_o));
	abort_c: cover property (@(posedge clk_i) disable iff (reset_i)
		state == pbs_pkg::PBS_BLANK ##1 state == pbs_pkg::PBS_LOCKOUT);
	host_kill_c: cover property (@(posedge clk_i) disable iff (reset_i)
		state == pbs_pkg::PBS_RUN ##1 state == pbs_pkg::PBS_LOCKOUT);
	grace_end_c: cover property (@(posedge clk_i) disable iff (reset_i)
		state == pbs_pkg::PBS_GRACE && tick && reached(ms_count, DELAY_MS));
endmodule : pbs_sequencer
`default_nettype wire

// [pbs_host_model.sv]
// Host processor model that drives the hold input of the sequencer
`timescale 1ns/1ps
`default_nettype none
module pbs_host_model (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        power_on_i,
	input  wire logic        alert_n_i,
	input  wire logic        kill_i,
	input  wire logic [1:0]  mode_i,
	input  wire logic [15:0] up_delay_i,
	input  wire logic [15:0] down_delay_i,
	output var  logic        power_hold_n_o
);
	logic        hold;
	logic [15:0] cnt;
	// Mode 1 never raises hold, mode 2 ignores the alert, mode 3 ties alert to hold
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hold <= 1'b0;
			cnt  <= 16'h0000;
		end else if (!power_on_i || kill_i) begin
			hold <= 1'b0;
			cnt  <= 16'h0000;
		end else if (alert_n_i && !hold && mode_i != 2'h1) begin
			if (cnt == up_delay_i) hold <= 1'b1;
			else cnt <= cnt + 16'h0001;
		end else if (alert_n_i) begin
			cnt <= 16'h0000;
		end else if (mode_i != 2'h2) begin
			// Once dropped, hold stays low until power goes, far above the minimum width
			if (cnt == down_delay_i) hold <= 1'b0;
			else cnt <= cnt + 16'h0001;
		end
	end
	assign power_hold_n_o = (mode_i == 2'h3) ? (hold & alert_n_i) : hold;
endmodule : pbs_host_model
`default_nettype wire

// [tb.sv]
// Self-checking testbench for the push button power sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s expected %h seen %h", n, e, g); end end
module tb;
	localparam int T = 4;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        pb_n = 1'b1;
	logic        kill = 1'b0;
	logic [1:0]  mode = 2'h0;
	logic [15:0] on_ext = 16'h0000;
	logic [15:0] off_ext = 16'h0000;
	logic [15:0] up_dly = 16'h0190;
	logic [15:0] down_dly = 16'h00C8;
	logic        hold_n, sup, sup_oe, alert_n, alert_oe, pwr, sup2, sup2_oe;
	int          failures = 0;
	int          checked = 0;
	wire logic   alert_line = alert_oe ? 1'b0 : 1'b1;
	pbs_sequencer #(.TICK_CYCLES(T)) i_pbs_sequencer (.clk_i(clk_i), .reset_i(reset_i),
		.push_button_n_i(pb_n), .power_hold_n_i(hold_n), .on_extend_i(on_ext),
		.off_extend_i(off_ext), .supply_on_out_o(sup), .supply_on_oe_o(sup_oe),
		.shutdown_alert_n_o(alert_n), .shutdown_alert_oe_o(alert_oe), .power_on_o(pwr));
	pbs_sequencer #(.SUPPLY_ACTIVE_HIGH(1'b0), .TICK_CYCLES(T)) i_pbs_sequencer_low (
		.clk_i(clk_i), .reset_i(reset_i), .push_button_n_i(pb_n), .power_hold_n_i(hold_n),
		.on_extend_i(on_ext), .off_extend_i(off_ext), .supply_on_out_o(sup2),
		.supply_on_oe_o(sup2_oe), .shutdown_alert_n_o(), .shutdown_alert_oe_o(),
		.power_on_o());
	pbs_host_model i_pbs_host_model (.clk_i(clk_i), .reset_i(reset_i), .power_on_i(pwr),
		.alert_n_i(alert_line), .kill_i(kill), .mode_i(mode), .up_delay_i(up_dly),
		.down_delay_i(down_dly), .power_hold_n_o(hold_n));
	always #12.5 clk_i = ~clk_i;
	function automatic logic cur(input bit sel);
		return sel ? alert_line : pwr;
	endfunction : cur
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	task automatic await(input bit sel, input logic want, input int lo, input int hi,
		input string what);
		int n;
		n = 0;
		while (cur(sel) !== want && n <= hi) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		`CHK(what, 1'b1, (n >= lo && n <= hi))
		`CHK("supply high variant", pwr, sup)
		`CHK("supply low variant", ~pwr, sup2)
		`CHK("drain enables", {~pwr, pwr}, {sup_oe, sup2_oe})
		if (n > hi) finish_test();
	endtask : await
	task automatic steady(input bit sel, input logic val, input int ms, input string what);
		int bad;
		bad = 0;
		repeat (ms * T) begin
			@(posedge clk_i);
			#1;
			if (cur(sel) !== val) bad++;
		end
		`CHK(what, 0, bad)
	endtask : steady
	task automatic press(input logic v);
		@(posedge clk_i);
		pb_n <= v;
	endtask : press
	task automatic power_up();
		press(1'b0);
		await(0, 1'b1, 31 * T, 33 * T + 4, "turn on time");
		press(1'b1);
		repeat (580 * T) @(posedge clk_i);
	endtask : power_up
	task automatic t_on_hold();
		@(posedge clk_i);
		on_ext <= 16'h0003;
		pb_n <= 1'b0;
		repeat (40) @(posedge clk_i);
		pb_n <= 1'b1;
		repeat (2) @(posedge clk_i);
		pb_n <= 1'b0;
		// Without the restart power would come about 98 cycles after the second press
		await(0, 1'b1, 34 * T, 36 * T + 4, "restarted debounce");
		steady(0, 1'b1, 600, "button held through blanking");
		press(1'b1);
		steady(0, 1'b1, 100, "running");
		@(posedge clk_i);
		on_ext <= 16'h0000;
		off_ext <= 16'h0002;
		pb_n <= 1'b0;
		await(1, 1'b0, 33 * T, 35 * T + 4, "alert after off press");
		`CHK("alert pin", 2'h1, {alert_n, alert_oe})
		press(1'b1);
		await(0, 1'b0, 190, 212, "host release");
		@(posedge clk_i);
		#1;
		`CHK("alert released", 1'b1, alert_line)
		repeat (40 * T) @(posedge clk_i);
		press(1'b0);
		// Pressed during the lockout; release debounce only counts after it, so the held press is ignored
		steady(0, 1'b0, 200, "lockout");
		steady(0, 1'b0, 60, "held across lockout end");
		press(1'b1);
		off_ext <= 16'h0000;
		$display("test on_hold_off done");
	endtask : t_on_hold
	task automatic t_abort();
		@(posedge clk_i);
		mode <= 2'h1;
		press(1'b0);
		await(0, 1'b1, 31 * T, 33 * T + 4, "abort turn on");
		press(1'b1);
		await(0, 1'b0, 510 * T, 513 * T, "blanking abort");
		repeat (300 * T) @(posedge clk_i);
		$display("test abort done");
	endtask : t_abort
	task automatic t_host_modes();
		mode <= 2'h0;
		up_dly <= 16'h0028;
		power_up();
		kill <= 1'b1;
		await(0, 1'b0, 0, 4, "kill in run");
		@(posedge clk_i);
		kill <= 1'b0;
		repeat (300 * T) @(posedge clk_i);
		mode <= 2'h2;
		power_up();
		press(1'b0);
		await(1, 1'b0, 31 * T, 33 * T + 4, "alert default");
		press(1'b1);
		await(0, 1'b0, 1023 * T, 1025 * T + 4, "grace expiry");
		repeat (300 * T) @(posedge clk_i);
		mode <= 2'h3;
		power_up();
		press(1'b0);
		await(1, 1'b0, 31 * T, 33 * T + 4, "tied alert");
		await(0, 1'b0, 0, 6, "tied release");
		press(1'b1);
		$display("test host modes done");
	endtask : t_host_modes
	initial begin
		repeat (3) @(posedge clk_i);
		#1;
		`CHK("reset outputs", 5'h09, {sup, alert_n, alert_oe, pwr, sup_oe})
		`CHK("reset low variant", 2'h2, {sup2, sup2_oe})
		@(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_on_hold();
		// Release must be debounced after the lockout before the next press counts
		repeat (60 * T) @(posedge clk_i);
		t_abort();
		t_host_modes();
		finish_test();
	end
endmodule : tb
`default_nettype wire
